/* common/serial_pkg.sv */
// Purpose: shared constants of the serial transfer core
// Assumes: 32-bit AXI4-Lite register access, 8-bit register offsets
// Notes: timer tick is a one-cycle enable from the programmable timer
package serial_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] TRIG_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] DATA_OFF = 8'h0C;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int STOP_BIT = 2;
  localparam int PAR_EN_BIT = 3;
  localparam int PAR_ODD_BIT = 4;
  localparam int TX_ENABLE_BIT = 5;
  localparam int RX_ENABLE_BIT = 6;
  localparam int TX_TRIGGER_BIT = 0;
  localparam int RX_TRIGGER_BIT = 1;
  localparam int PERR_BIT = 0;
  localparam int FERR_BIT = 1;
  localparam int OERR_BIT = 2;
  localparam int RXERR_EV_BIT = 3;
  localparam int RXDONE_EV_BIT = 4;
  localparam int TXDONE_EV_BIT = 5;
  // ----------------------------------------------------------------
  // modes and timing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SYNC_MASTER = 2'h0,
    MODE_SYNC_SLAVE = 2'h1,
    MODE_ASYNC7 = 2'h2,
    MODE_ASYNC8 = 2'h3
  } mode_t;
  localparam logic [3:0] SAMPLE_FALL_TICK = 4'h2;
  localparam logic [3:0] SAMPLE_RISE_TICK = 4'h8;
  localparam logic [3:0] SCLK_FALL_TICK = 4'h0;
  localparam logic [3:0] SCLK_RISE_TICK = 4'h8;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] SYNC_LAST_BIT = 4'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* rtl/pin_sync.sv */
// Purpose: three-stage synchroniser for one external pin
// Assumes: pin is asynchronous to aclk
// Notes: output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  output logic level
);
  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;
  logic level_reg;
  wire agree = (ff2_reg == ff3_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff1_reg <= INIT;
      ff2_reg <= INIT;
      ff3_reg <= INIT;
      level_reg <= INIT;
    end else begin
      ff1_reg <= pin;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      if (agree) begin
        level_reg <= ff3_reg;
      end
    end
  end

  assign level = level_reg;
endmodule
`default_nettype wire

/* rtl/serial_txrx_control.sv */
// Purpose: serial transfer core, sync master/slave and 7/8-bit async
// Assumes: timer_tick is a one-cycle pulse at 16x baud rate
// Notes: registers over AXI4-Lite, only byte lane 0 carries fields
// Operation
// - master shift clock is timer tick over sixteen
// - slave shifts on external clock pin edges
// - async bit timing uses sixteen ticks per bit
// - sample strobe falls tick two, rises tick eight
// - sample on strobe rise, idle strobe high
// - start not low at sample abandons frame
// - async transmit bit clock is tick over sixteen
// - written data byte is serialised onto output
// - async receive buffered, sync read from shifter
// - transmit enable gates transmitter, either enable drives clock pin in master mode only
// - trigger after data starts send, done event
// - transmit trigger reads one while sending
// - receive enable arms receiver and done event
// - sync receive trigger starts, slave ready low
// - async receive trigger releases buffer
// - receive trigger reads one while receiving
// - parity mismatch sets parity and error flags
// - zero stop bit sets framing and error flags
// - unreleased or unread slave data sets overrun
// - error flags write-one-clear, data still loaded
// - load with release same cycle is overrun
// - two-bit field selects the four modes
// - async frame format, reset one stop no parity
// - overrun alone does not set receive done
`timescale 1ns/100ps
`default_nettype none
module serial_txrx_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [serial_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [serial_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [serial_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [serial_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic timer_tick,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  input wire logic sclk_in_pin,
  output logic sclk_out_pin,
  output logic sclk_oe_n,
  output logic slave_ready_n
);
  import serial_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [DATA_W-1:0] rdata_reg, wdata_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic wlane_reg;
  logic [7:0] ctrl_reg, txrx_data_reg;
  logic [5:0] flags_reg;
  logic sync_run_reg, sync_tx_reg, sync_rx_reg, rx_unread_reg;
  logic [7:0] sh_reg;
  logic [3:0] sc_cnt_reg, sync_bits_reg;
  logic sclk_prev_reg, sclk_out_reg, sclk_oe_n_reg, slave_ready_n_reg, serial_out_reg;
  logic atx_busy_reg;
  logic [11:0] atx_frame_reg;
  logic [3:0] atx_left_reg, atx_cnt_reg;
  rx_state_t rx_state_reg;
  logic [3:0] rx_tcnt_reg, rx_idx_reg;
  logic [7:0] rx_sh_reg, rx_buf_reg;
  logic rx_par_reg, rx_ferr_reg, rx_strobe_reg, buf_full_reg;
  logic sin_s, sclk_s;

  pin_sync sin_sync (.aclk(aclk), .aresetn(aresetn), .pin(serial_in_pin), .level(sin_s));
  pin_sync sclk_sync (.aclk(aclk), .aresetn(aresetn), .pin(sclk_in_pin), .level(sclk_s));

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  wire [1:0] transfer_mode_sel = ctrl_reg[MODE_LSB +: 2];
  wire stop_bits_sel = ctrl_reg[STOP_BIT];
  wire parity_enable = ctrl_reg[PAR_EN_BIT];
  wire parity_odd_select = ctrl_reg[PAR_ODD_BIT];
  wire tx_enable = ctrl_reg[TX_ENABLE_BIT];
  wire rx_enable = ctrl_reg[RX_ENABLE_BIT];
  wire is_master = (transfer_mode_sel == MODE_SYNC_MASTER);
  wire is_slave = (transfer_mode_sel == MODE_SYNC_SLAVE);
  wire is_sync = is_master | is_slave;
  wire is_async = !is_sync;
  wire is_eight = (transfer_mode_sel == MODE_ASYNC8);
  wire [3:0] dlen = is_eight ? 4'h8 : 4'h7;
  wire [3:0] stops = stop_bits_sel ? 4'h2 : 4'h1;
  wire [3:0] rx_len = dlen + {3'h0, parity_enable} + stops;
  wire [3:0] atx_len = 4'h1 + rx_len;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire aw_fire = awvalid & awready_reg;
  wire w_fire = wvalid & wready_reg;
  wire ar_fire = arvalid & arready_reg;
  wire wr_do = !awready_reg & !wready_reg & !bvalid_reg;
  wire wr_en = wr_do & wlane_reg;
  wire wr_map = (awaddr_reg == CTRL_OFF) | (awaddr_reg == TRIG_OFF) |
                (awaddr_reg == STAT_OFF) | (awaddr_reg == DATA_OFF);
  wire wr_ctrl = wr_en & (awaddr_reg == CTRL_OFF);
  wire wr_trig = wr_en & (awaddr_reg == TRIG_OFF);
  wire wr_stat = wr_en & (awaddr_reg == STAT_OFF);
  wire wr_data = wr_en & (awaddr_reg == DATA_OFF);
  wire rd_map = (araddr == CTRL_OFF) | (araddr == TRIG_OFF) |
                (araddr == STAT_OFF) | (araddr == DATA_OFF);
  wire rd_data = ar_fire & (araddr == DATA_OFF);
  wire tx_busy = atx_busy_reg | (sync_run_reg & sync_tx_reg);
  wire rx_busy = (rx_state_reg != RX_IDLE) | (sync_run_reg & sync_rx_reg);
  wire tx_trigger = wr_trig & wdata_reg[TX_TRIGGER_BIT];
  wire rx_trigger = wr_trig & wdata_reg[RX_TRIGGER_BIT];
  wire tx_go = tx_trigger & tx_enable & !tx_busy;
  wire rx_go_sync = rx_trigger & rx_enable & is_sync & !sync_run_reg;
  wire rx_release = rx_trigger & is_async;
  wire [7:0] rd_byte = is_sync ? sh_reg : rx_buf_reg;
  wire [DATA_W-1:0] rd_word =
    (araddr == CTRL_OFF) ? {24'h00_0000, ctrl_reg} :
    (araddr == TRIG_OFF) ? {30'h0000_0000, rx_busy, tx_busy} :
    (araddr == STAT_OFF) ? {26'h000_0000, flags_reg} :
    (araddr == DATA_OFF) ? {24'h00_0000, rd_byte} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wlane_reg <= 1'b0;
    end else begin
      if (aw_fire) begin
        awaddr_reg <= awaddr;
        awready_reg <= 1'b0;
      end
      if (w_fire) begin
        wdata_reg <= wdata;
        wlane_reg <= wstrb[0];
        wready_reg <= 1'b0;
      end
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg & bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (ar_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg & rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // clocked-synchronous engine
  // ----------------------------------------------------------------
  wire sync_start = is_sync & !sync_run_reg & (tx_go | rx_go_sync);
  wire m_tick = is_master & sync_run_reg & timer_tick;
  wire fall_ev = m_tick ? (sc_cnt_reg == SCLK_FALL_TICK) :
                 (is_slave & sync_run_reg & sclk_prev_reg & !sclk_s);
  wire rise_ev = m_tick ? (sc_cnt_reg == SCLK_RISE_TICK) :
                 (is_slave & sync_run_reg & !sclk_prev_reg & sclk_s);
  wire sync_done = rise_ev & (sync_bits_reg == SYNC_LAST_BIT);
  wire sync_rx_done = sync_done & sync_rx_reg;
  wire sync_ovr = sync_rx_done & is_slave & rx_unread_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_run_reg <= 1'b0;
      sync_tx_reg <= 1'b0;
      sync_rx_reg <= 1'b0;
      sh_reg <= 8'h00;
      sc_cnt_reg <= 4'h0;
      sync_bits_reg <= 4'h0;
      sclk_prev_reg <= 1'b1;
      rx_unread_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
      if (sync_start) begin
        sync_run_reg <= 1'b1;
        sync_tx_reg <= tx_go;
        sync_rx_reg <= rx_go_sync | rx_enable;
        sh_reg <= txrx_data_reg;
        sc_cnt_reg <= 4'h0;
        sync_bits_reg <= 4'h0;
      end else if (sync_run_reg) begin
        if (!(tx_enable | rx_enable) | is_async) begin
          sync_run_reg <= 1'b0;
        end
        if (m_tick) begin
          sc_cnt_reg <= sc_cnt_reg + 4'h1;
        end
        if (rise_ev) begin
          sh_reg <= {sin_s, sh_reg[7:1]};
          sync_bits_reg <= sync_bits_reg + 4'h1;
        end
        if (sync_done) begin
          sync_run_reg <= 1'b0;
        end
      end
      if (sync_rx_done) begin
        rx_unread_reg <= 1'b1;
      end else if (rd_data) begin
        rx_unread_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // asynchronous transmitter
  // ----------------------------------------------------------------
  wire par_out = parity_enable ? (^txrx_data_reg[6:0] ^ (is_eight & txrx_data_reg[7]) ^
                                  parity_odd_select) : 1'b1;
  wire [8:0] tx_body = is_eight ? {par_out, txrx_data_reg} : {1'b1, par_out, txrx_data_reg[6:0]};
  wire [11:0] tx_frame = {2'h3, tx_body, 1'b0};
  wire atx_bit_end = atx_busy_reg & timer_tick & (atx_cnt_reg == TICK_LAST);
  wire atx_done = atx_bit_end & (atx_left_reg == 4'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      atx_busy_reg <= 1'b0;
      atx_frame_reg <= 12'hFFF;
      atx_left_reg <= 4'h0;
      atx_cnt_reg <= 4'h0;
    end else if (tx_go & is_async) begin
      atx_busy_reg <= 1'b1;
      atx_frame_reg <= tx_frame;
      atx_left_reg <= atx_len;
      atx_cnt_reg <= 4'h0;
    end else if (atx_busy_reg) begin
      if (timer_tick) begin
        atx_cnt_reg <= atx_cnt_reg + 4'h1;
      end
      if (atx_bit_end) begin
        atx_frame_reg <= {1'b1, atx_frame_reg[11:1]};
        atx_left_reg <= atx_left_reg - 4'h1;
      end
      if (atx_done | !tx_enable) begin
        atx_busy_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // asynchronous receiver
  // ----------------------------------------------------------------
  wire [3:0] rx_tcnt_inc = rx_tcnt_reg + 4'h1;
  wire rx_active = (rx_state_reg != RX_IDLE);
  wire rx_sample = rx_active & timer_tick & (rx_tcnt_inc == SAMPLE_RISE_TICK);
  wire [3:0] rx_pos = rx_len - rx_idx_reg;
  wire rx_is_data = rx_pos < dlen;
  wire rx_is_par = parity_enable & (rx_pos == dlen);
  wire rx_is_stop = !rx_is_data & !rx_is_par;
  wire rx_stop_bad = rx_is_stop & !sin_s;
  wire rx_load = rx_sample & (rx_state_reg == RX_BITS) & (rx_idx_reg == 4'h1);
  wire frame_bad = rx_ferr_reg | rx_stop_bad;
  wire par_bad = parity_enable & (rx_par_reg ^ parity_odd_select);
  wire [7:0] rx_byte = is_eight ? rx_sh_reg : {1'b0, rx_sh_reg[7:1]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_reg <= RX_IDLE;
      rx_tcnt_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_par_reg <= 1'b0;
      rx_ferr_reg <= 1'b0;
      rx_strobe_reg <= 1'b1;
    end else if (!rx_enable | is_sync) begin
      rx_state_reg <= RX_IDLE;
      rx_strobe_reg <= 1'b1;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          rx_strobe_reg <= 1'b1;
          if (timer_tick & !sin_s) begin
            rx_state_reg <= RX_START;
            rx_tcnt_reg <= 4'h0;
            rx_par_reg <= 1'b0;
            rx_ferr_reg <= 1'b0;
          end
        end
        RX_START: begin
          if (rx_sample) begin
            rx_state_reg <= sin_s ? RX_IDLE : RX_BITS;
            rx_idx_reg <= rx_len;
          end
        end
        default: begin
          if (rx_sample) begin
            if (rx_is_data) begin
              rx_sh_reg <= {sin_s, rx_sh_reg[7:1]};
            end
            if (!rx_is_stop) begin
              rx_par_reg <= rx_par_reg ^ sin_s;
            end
            rx_ferr_reg <= frame_bad;
            rx_idx_reg <= rx_idx_reg - 4'h1;
            if (rx_load) begin
              rx_state_reg <= RX_IDLE;
            end
          end
        end
      endcase
      if (rx_active & timer_tick) begin
        rx_tcnt_reg <= rx_tcnt_inc;
        if (rx_tcnt_inc == SAMPLE_FALL_TICK) begin
          rx_strobe_reg <= 1'b0;
        end else if (rx_tcnt_inc == SAMPLE_RISE_TICK) begin
          rx_strobe_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_reg <= 8'h00;
      buf_full_reg <= 1'b0;
    end else begin
      if (rx_load) begin
        rx_buf_reg <= rx_byte;
      end
      buf_full_reg <= rx_load | (buf_full_reg & !rx_release);
    end
  end

  // ----------------------------------------------------------------
  // control registers and event flags
  // ----------------------------------------------------------------
  wire async_ovr = rx_load & (buf_full_reg | rx_release);
  wire set_perr = rx_load & par_bad;
  wire set_ferr = rx_load & frame_bad;
  wire set_oerr = async_ovr | sync_ovr;
  wire set_rxerr = set_perr | set_ferr | set_oerr;
  wire set_rxdone = (rx_load & (!async_ovr | par_bad | frame_bad)) | (sync_rx_done & !sync_ovr);
  wire set_txdone = atx_done | (sync_done & sync_tx_reg);
  wire [5:0] set_vec = {set_txdone, set_rxdone, set_rxerr, set_oerr, set_ferr, set_perr};
  wire [5:0] clr_vec = wr_stat ? wdata_reg[5:0] : 6'h00;
  wire [5:0] flags_next = set_vec | (flags_reg & ~clr_vec);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      txrx_data_reg <= DATA_RESET;
      flags_reg <= FLAGS_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata_reg[7:0];
      end
      if (wr_data) begin
        txrx_data_reg <= wdata_reg[7:0];
      end
      flags_reg <= flags_next;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  wire serial_out_next = atx_busy_reg ? atx_frame_reg[0] :
                         sync_run_reg ? (fall_ev ? sh_reg[0] : serial_out_reg) : 1'b1;
  wire sclk_out_next = (is_master & sync_run_reg) ?
                       (fall_ev ? 1'b0 : (rise_ev ? 1'b1 : sclk_out_reg)) : 1'b1;
  wire ready_next = !is_slave ? 1'b1 : (sync_start ? 1'b0 : (sync_done ? 1'b1 : slave_ready_n_reg));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_out_reg <= 1'b1;
      sclk_out_reg <= 1'b1;
      sclk_oe_n_reg <= 1'b1;
      slave_ready_n_reg <= 1'b1;
    end else begin
      serial_out_reg <= serial_out_next;
      sclk_out_reg <= sclk_out_next;
      sclk_oe_n_reg <= !(is_master & (tx_enable | rx_enable));
      slave_ready_n_reg <= ready_next;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign serial_out_pin = serial_out_reg;
  assign sclk_out_pin = sclk_out_reg;
  assign sclk_oe_n = sclk_oe_n_reg;
  assign slave_ready_n = slave_ready_n_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_strobe_fall: assert property (rx_active && timer_tick && rx_tcnt_reg == 4'h1 && rx_enable && is_async
    |=> !rx_strobe_reg) else $error("strobe did not fall");
  chk_strobe_idle: assert property (rx_state_reg == RX_IDLE |-> rx_strobe_reg)
    else $error("strobe low while idle");
  chk_start_abandon: assert property (rx_state_reg == RX_START && rx_sample && sin_s && rx_enable && is_async
    |=> rx_state_reg == RX_IDLE) else $error("bad start kept");
  chk_sclk_divide: assert property (is_master && sync_run_reg && $changed(sclk_out_reg) && $past(sync_run_reg)
    |-> $past(timer_tick)) else $error("sclk moved off tick");
  chk_overrun_set: assert property (rx_load && buf_full_reg |=> flags_reg[OERR_BIT] && flags_reg[RXERR_EV_BIT])
    else $error("overrun missed");
  chk_frame_err: assert property (rx_load && rx_stop_bad |=> flags_reg[FERR_BIT] && flags_reg[RXDONE_EV_BIT])
    else $error("framing error missed");
  chk_set_wins: assert property (set_perr && clr_vec[PERR_BIT] |=> flags_reg[PERR_BIT])
    else $error("clear beat set");
  chk_slave_ready: assert property (is_slave && rx_go_sync |=> !slave_ready_n ##0 sync_run_reg)
    else $error("ready not low");
  chk_tx_idle_line: assert property (!atx_busy_reg && !sync_run_reg |=> serial_out_pin)
    else $error("line not idle high");
  cov_async_frame: cover property (rx_load && !par_bad && !frame_bad);
  cov_sync_done: cover property (sync_done && sync_tx_reg);
  cov_overrun: cover property (async_ovr && rx_release);
  cov_abandon: cover property (rx_state_reg == RX_START && rx_sample && sin_s);
endmodule
`default_nettype wire

/* tb/serial_peer.sv */
// Purpose: far-end async transmitter and sync master model
// Assumes: tick is the 16x bit-rate enable
// Notes: line rests high between frames
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
  input wire logic aclk,
  input wire logic tick,
  output logic line,
  output logic sclk
);
  initial line = 1'b1;
  initial sclk = 1'b1;
  task automatic shift_in(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      sclk <= 1'b0;
      line <= b[i];
      repeat (8) @(posedge aclk);
      sclk <= 1'b1;
      repeat (8) @(posedge aclk);
    end
    line <= 1'b1;
  endtask
  task automatic bit_out(input logic v);
    line <= v;
    repeat (16) begin
      @(posedge aclk);
      while (tick !== 1'b1) @(posedge aclk);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic stop);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(b[i]);
    bit_out(stop);
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/serial_txrx_control_test.sv */
// Purpose: bench for the serial transfer core
// Assumes: tick every second cycle
// Notes: bready and rready stay high
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; \
  $display("Error %s exp %0h got %0h", n, e, s); end end
module serial_txrx_control_test;
  import serial_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, timer_tick = 0;
  logic bready = 1, rready = 1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd_d;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic awready, wready, bvalid, arready, rvalid, serial_in_pin;
  logic serial_out_pin, sclk_out_pin, sclk_oe_n, slave_ready_n, sclk_in;
  int err_count = 0, check_count = 0;
  serial_txrx_control DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'h1),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .timer_tick, .serial_in_pin, .serial_out_pin, .sclk_in_pin(sclk_in),
    .sclk_out_pin, .sclk_oe_n, .slave_ready_n);
  serial_peer peer (.aclk(aclk), .tick(timer_tick), .line(serial_in_pin), .sclk(sclk_in));
  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) timer_tick <= ~timer_tick;
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic fail_wait(input string what);
    err_count++;
    $display("Error %s exp done got timeout", what);
    end_of_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    wr_r = bresp;
    if (n >= 100) fail_wait("write");
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    rd_r = rresp;
    if (n >= 100) fail_wait("read");
  endtask
  task automatic poll(input logic [31:0] m);
    int n = 0;
    do begin
      rd(STAT_OFF, rd_d);
      n++;
    end while ((rd_d & m) == 0 && n < 300);
    if (n >= 300) fail_wait("poll");
  endtask
  task automatic t_reset();
    rd(CTRL_OFF, rd_d);
    `CHK("ctrl", 32'h0000_0000, rd_d)
    rd(8'h10, rd_d);
    `CHK("unmapped", RESP_SLVERR, rd_r)
    wr(8'h10, 32'h0000_00ff);
    `CHK("wr unmapped", RESP_SLVERR, wr_r)
    $display("test reset done");
  endtask
  task automatic t_tx();
    logic [7:0] b = 8'ha5;
    int n = 0;
    wr(CTRL_OFF, 32'h0000_0003);
    wr(CTRL_OFF, 32'h0000_0023);
    wr(DATA_OFF, 32'h0000_00a5);
    wr(TRIG_OFF, 32'h0000_0001);
    rd(TRIG_OFF, rd_d);
    `CHK("tx busy", 1'b1, rd_d[0])
    while (serial_out_pin === 1'b1 && n++ < 50) @(posedge aclk);
    if (n > 50) fail_wait("start bit");
    repeat (16) @(posedge aclk);
    `CHK("start", 1'b0, serial_out_pin)
    for (int i = 0; i < 8; i++) begin
      repeat (32) @(posedge aclk);
      `CHK("tx bit", b[i], serial_out_pin)
    end
    repeat (32) @(posedge aclk);
    `CHK("stop", 1'b1, serial_out_pin)
    poll(32'h0000_0020);
    rd(TRIG_OFF, rd_d);
    `CHK("tx idle", 1'b0, rd_d[0])
    $display("test tx done");
  endtask
  task automatic t_rx();
    wr(CTRL_OFF, 32'h0000_0043);
    wr(STAT_OFF, 32'h0000_003f);
    peer.send(8'h3c, 1'b1);
    poll(32'h0000_0010);
    rd(DATA_OFF, rd_d);
    `CHK("rx byte", 32'h0000_003c, rd_d)
    wr(STAT_OFF, 32'h0000_003f);
    peer.send(8'h5a, 1'b1);
    poll(32'h0000_0004);
    `CHK("overrun", 32'h0000_000c, rd_d)
    rd(DATA_OFF, rd_d);
    `CHK("rx after err", 32'h0000_005a, rd_d)
    wr(STAT_OFF, 32'h0000_003f);
    rd(STAT_OFF, rd_d);
    `CHK("w1c", 32'h0000_0000, rd_d)
    wr(TRIG_OFF, 32'h0000_0002);
    peer.send(8'h81, 1'b0);
    poll(32'h0000_0008);
    `CHK("framing", 32'h0000_001a, rd_d)
    $display("test rx done");
  endtask
  task automatic t_sync();
    int m = 0;
    wr(CTRL_OFF, 32'h0000_0000);
    wr(CTRL_OFF, 32'h0000_0020);
    @(posedge aclk);
    `CHK("sclk_oe_n", 1'b0, sclk_oe_n)
    wr(DATA_OFF, 32'h0000_0096);
    wr(TRIG_OFF, 32'h0000_0001);
    while (sclk_out_pin === 1'b1 && m++ < 100) @(posedge aclk);
    if (m > 100) fail_wait("sclk fall");
    m = 0;
    while (sclk_out_pin === 1'b0 && m++ < 100) @(posedge aclk);
    while (sclk_out_pin === 1'b1 && m++ < 100) @(posedge aclk);
    if (m > 100) fail_wait("sclk period");
    `CHK("sclk period", 32, m)
    poll(32'h0000_0020);
    $display("test sync done");
  endtask
  task automatic t_slave();
    wr(CTRL_OFF, 32'h0000_0000);
    wr(CTRL_OFF, 32'h0000_0041);
    `CHK("slave oe", 1'b1, sclk_oe_n)
    wr(TRIG_OFF, 32'h0000_0002);
    `CHK("ready low", 1'b0, slave_ready_n)
    peer.shift_in(8'h6b);
    poll(32'h0000_0010);
    `CHK("ready high", 1'b1, slave_ready_n)
    rd(DATA_OFF, rd_d);
    `CHK("slave byte", 32'h0000_006b, rd_d)
    $display("test slave done");
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_tx();
    t_rx();
    t_sync();
    t_slave();
    end_of_test();
  end
endmodule
`default_nettype wire
